// File: hw/mrc_ctrl_regs.v
// write-only control register group of the multiplex data receiver
// Functional notes
// - frame marks four per frame steer guard
// - guard counts back high, forward low, minus one
// - control_one reset zero; bit0 selects method A
// - method A allows twelve data in parity
// - option change keeps lock forward count
// - bit2 halts column and second row fix
// - bit3 halts correction, memory and output
// - bit4 clears sync state, keeps configuration
// - during sync resets no interrupt, output released
// - bit5 clear outputs only clean locked data
// - bit6 clear releases serial output when idle
// - bit7 clears group check division register
// - control_two dma enable and strobe select
// - control_two bit2 outputs uncorrected frames
// - control_two bit3 selects ready timing
// - bits4,5 set request and acknowledge polarity
// - control_two bit6 resets block lock, not frame lock; quiets outputs
// - group check bytes at offset six, parallel
// - check divides by x16+x12+x5+1, zero passes
// - interface select chooses serial or parallel
// - guard counter counts match or mismatch
`timescale 1ns/100ps
`include "mrc_map.vh"
module mrc_ctrl_regs #(
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW    = 4
) (
    input  wire       clk,
    input  wire       arst_n,
    input  wire       interface_select,
    input  wire       par_wr,
    input  wire [3:0] par_addr,
    input  wire [7:0] par_wdata,
    input  wire       ser_wr,
    input  wire [3:0] ser_addr,
    input  wire [7:0] ser_wdata,
    input  wire       ser_gchk_valid,
    input  wire [7:0] ser_gchk_data,
    output wire       gchk_ready,
    input  wire       frame_mark,
    input  wire       frame_match,
    input  wire       block_mark,
    input  wire       block_match,
    input  wire       word_valid,
    input  wire       word_corrected,
    input  wire       word_l2_ok,
    input  wire       word_column_fixed,
    input  wire       frame_error_free,
    input  wire       int_raw,
    input  wire       ser_data_raw,
    input  wire       ser_data_active,
    input  wire       transfer_request_raw,
    input  wire       transfer_acknowledge,
    output reg        frame_lock_q,
    output reg        block_lock_q,
    output reg        frame_method_a_q,
    output reg        realtime_block_option_q,
    output reg        column_fix_halt_q,
    output reg        correction_stop_q,
    output reg        word_out_q,
    output reg        int_out_q,
    output reg        ser_out_q,
    output reg        ser_oe_q,
    output reg        transfer_request_q,
    output reg        read_strobe_q,
    output reg        dma_enable_q,
    output reg        ready_timing2_q,
    output reg        substation_flag_q,
    output reg        group_check_ok_q
);

    //------------------------------------------------------------------
    // register file
    //------------------------------------------------------------------
    reg  [7:0] guard_q;
    reg  [7:0] control_one_q;
    reg  [7:0] control_two_q;
    wire       wr_en;
    wire [3:0] wr_addr;
    wire [7:0] wr_data;
    wire       par_mode;

    // interface select picks which bus writes the registers
    assign par_mode = ~interface_select;
    assign wr_en    = par_mode ? par_wr : ser_wr;
    assign wr_addr  = par_mode ? par_addr : ser_addr;
    assign wr_data  = par_mode ? par_wdata : ser_wdata;

    // configuration writes, effective from the next cycle
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            guard_q <= `MRC_RST_GUARD;
            control_one_q  <= `MRC_RST_CONTROL_ONE;
            control_two_q  <= `MRC_RST_CONTROL_TWO;
        end
        else if (wr_en)
        begin
            case (wr_addr)
                `MRC_OFS_GUARD: guard_q <= wr_data;
                `MRC_OFS_CONTROL_ONE:  control_one_q  <= wr_data;
                `MRC_OFS_CONTROL_TWO:  control_two_q  <= wr_data;
                default:        ;
            endcase
        end
    end

    // named control fields
    wire frame_a    = control_one_q[`MRC_C1_FRAME_A];
    wire no_rtb     = control_one_q[`MRC_C1_NO_RTB];
    wire col_halt   = control_one_q[`MRC_C1_COL_HALT];
    wire corr_stop  = control_one_q[`MRC_C1_CORR_STOP];
    wire sync_rst   = control_one_q[`MRC_C1_SYNC_RST];
    wire out_all    = control_one_q[`MRC_C1_OUT_ALL];
    wire ser_move   = control_one_q[`MRC_C1_SER_MOVE];
    wire gchk_clr   = control_one_q[`MRC_C1_GCHK_CLR];
    wire uncorr_out = control_two_q[`MRC_C2_UNCORR_OUT];
    wire block_lock_reset    = control_two_q[`MRC_C2_BLOCK_LOCK_RESET];
    wire req_pol    = control_two_q[`MRC_C2_REQ_POL];
    wire ack_pol    = control_two_q[`MRC_C2_ACK_POL];
    wire any_rst    = sync_rst | block_lock_reset;

    // guard limit: stored value plus one gives the count
    function [4:0] guard_limit;
        input [3:0] field;
        begin
            guard_limit = {1'b0, field} + 5'h01;
        end
    endfunction

    // guard counter step: back mode counts matches, forward misses
    function [4:0] guard_step;
        input [4:0] cnt;
        input       locked;
        input       match;
        begin
            if (locked ? ~match : match)
                guard_step = (cnt == 5'h1F) ? cnt : cnt + 5'h01;
            else
                guard_step = 5'h00;
        end
    endfunction

    //------------------------------------------------------------------
    // frame lock guard
    //------------------------------------------------------------------
    reg  [4:0] fcnt_q;
    reg  [4:0] fcnt_d;
    reg        flock_d;
    reg  [1:0] mark_q;
    reg        rtb_prev_q;
    reg        rtb_drop_q;
    reg  [4:0] rtb_cnt_q;
    wire [4:0] fwd_lim  = guard_limit(guard_q[3:0]);
    wire [4:0] back_lim = guard_limit(guard_q[7:4]);

    // next frame lock state from each block id mark
    always @*
    begin
        fcnt_d  = fcnt_q;
        flock_d = frame_lock_q;
        if (frame_mark)
        begin
            fcnt_d = guard_step(fcnt_q, frame_lock_q, frame_match);
            if (!frame_lock_q && fcnt_d >= back_lim)
            begin
                flock_d = 1'b1;
                fcnt_d  = 5'h00;
            end
            else if (frame_lock_q && fcnt_d >= fwd_lim)
            begin
                flock_d = 1'b0;
                fcnt_d  = 5'h00;
            end
        end
    end

    // frame lock, mark position within frame, option change hold
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            frame_lock_q <= 1'b0;
            fcnt_q       <= 5'h00;
            mark_q       <= 2'h0;
            rtb_prev_q   <= 1'b0;
            rtb_drop_q   <= 1'b0;
            rtb_cnt_q    <= 5'h00;
        end
        else if (sync_rst)
        begin
            frame_lock_q <= 1'b0;
            fcnt_q       <= 5'h00;
            mark_q       <= 2'h0;
            rtb_prev_q   <= no_rtb;
            rtb_drop_q   <= 1'b0;
            rtb_cnt_q    <= 5'h00;
        end
        else
        begin
            rtb_prev_q <= no_rtb;
            if (frame_mark)
                mark_q <= (mark_q == `MRC_MARKS_PER_FRAME - 1) ?
                          2'h0 : mark_q + 2'h1;
            if (rtb_prev_q != no_rtb && frame_lock_q)
            begin
                rtb_drop_q <= 1'b1;
                rtb_cnt_q  <= 5'h00;
            end
            if (rtb_drop_q)
            begin
                // lock held for the forward count of marks, then lost
                if (frame_mark)
                    rtb_cnt_q <= rtb_cnt_q + 5'h01;
                if (frame_mark && rtb_cnt_q + 5'h01 >= fwd_lim)
                begin
                    frame_lock_q <= 1'b0;
                    fcnt_q       <= 5'h00;
                    rtb_drop_q   <= 1'b0;
                end
            end
            else
            begin
                frame_lock_q <= flock_d;
                fcnt_q       <= fcnt_d;
            end
        end
    end

    //------------------------------------------------------------------
    // block lock guard (fixed counts, the block count register lies
    // outside this group)
    //------------------------------------------------------------------
    reg  [4:0] bcnt_q;
    reg  [4:0] bcnt_n;
    wire [7:0] blk_guard = `MRC_RST_GUARD;

    always @*
    begin
        bcnt_n = guard_step(bcnt_q, block_lock_q, block_match);
    end

    // block lock follows the same guard scheme with reset values
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            block_lock_q <= 1'b0;
            bcnt_q       <= 5'h00;
        end
        else if (any_rst)
        begin
            block_lock_q <= 1'b0;
            bcnt_q       <= 5'h00;
        end
        else if (block_mark)
        begin
            if (bcnt_n >= guard_limit(block_lock_q ? blk_guard[3:0]
                                                   : blk_guard[7:4]))
            begin
                block_lock_q <= ~block_lock_q;
                bcnt_q       <= 5'h00;
            end
            else
                bcnt_q <= bcnt_n;
        end
    end

    //------------------------------------------------------------------
    // output gating
    //------------------------------------------------------------------
    wire clean_ok = word_corrected & word_l2_ok & block_lock_q
                    & frame_lock_q;
    wire fix_ok   = col_halt | word_column_fixed
                    | (uncorr_out & frame_error_free);
    wire pass     = (out_all | clean_ok) & fix_ok;
    wire run_out  = ~corr_stop & ~any_rst;

    // data output, interrupt and serial pin control
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            word_out_q <= 1'b0;
            int_out_q  <= 1'b0;
            ser_out_q  <= 1'b1;
            ser_oe_q   <= 1'b0;
        end
        else
        begin
            word_out_q <= word_valid & pass & run_out;
            int_out_q  <= int_raw & run_out;
            if (any_rst || !interface_select)
            begin
                ser_oe_q  <= 1'b0;
                ser_out_q <= 1'b1;
            end
            else if (ser_move)
            begin
                ser_oe_q  <= 1'b1;
                ser_out_q <= ser_data_raw | ~int_raw;
            end
            else
            begin
                ser_oe_q  <= ser_data_active & ~corr_stop;
                ser_out_q <= ser_data_raw | ~ser_data_active;
            end
        end
    end

    //------------------------------------------------------------------
    // transfer and mode outputs
    //------------------------------------------------------------------
    wire ack_act = transfer_acknowledge ~^ ack_pol;
    wire dma_on  = par_mode & control_two_q[`MRC_C2_DMA_EN];

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            transfer_request_q      <= 1'b1;
            read_strobe_q           <= 1'b0;
            dma_enable_q            <= 1'b0;
            ready_timing2_q         <= 1'b0;
            substation_flag_q       <= 1'b0;
            frame_method_a_q        <= 1'b0;
            realtime_block_option_q <= 1'b0;
            column_fix_halt_q       <= 1'b0;
            correction_stop_q       <= 1'b0;
        end
        else
        begin
            // request drawn at the chosen polarity
            transfer_request_q <= (dma_on & transfer_request_raw
                                   & run_out) ~^ req_pol;
            read_strobe_q      <= dma_on & control_two_q[`MRC_C2_DMA_ACK_RD]
                                  & ack_act;
            dma_enable_q       <= dma_on;
            ready_timing2_q    <= par_mode & control_two_q[`MRC_C2_RDY_T2];
            substation_flag_q  <= control_two_q[`MRC_C2_SUBST];
            frame_method_a_q   <= frame_a;
            realtime_block_option_q <= no_rtb;
            column_fix_halt_q  <= col_halt;
            correction_stop_q  <= corr_stop;
        end
    end

    //------------------------------------------------------------------
    // group check: bytes queue in the fifo, then divide bitwise
    //------------------------------------------------------------------
    wire       par_gchk = par_mode & par_wr
                          & (par_addr == `MRC_OFS_GCHK);
    wire       in_v     = par_gchk | (~par_mode & ser_gchk_valid);
    wire [7:0] in_d     = par_mode ? par_wdata : ser_gchk_data;
    wire [7:0] f_data;
    wire       f_valid;
    reg        f_ready;
    reg [15:0] crc_q;
    reg [7:0]  sh_q;
    reg [3:0]  bits_q;

    mrc_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_gchk_fifo (
        .clk       (clk),
        .arst_n    (arst_n),
        .in_data   (in_d),
        .in_valid  (in_v),
        .in_ready  (gchk_ready),
        .out_data  (f_data),
        .out_valid (f_valid),
        .out_ready (f_ready)
    );

    // one division step per bit, msb first
    function [15:0] crc_bit;
        input [15:0] c;
        input        b;
        begin
            crc_bit = {c[14:0], 1'b0}
                      ^ ((c[15] ^ b) ? `MRC_CRC_POLY : 16'h0000);
        end
    endfunction

    always @*
    begin
        f_ready = (bits_q == 4'h0) & ~gchk_clr;
    end

    // division register; clear holds it and the bit count at zero, the shifter keeps its byte
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            crc_q            <= 16'h0000;
            sh_q             <= 8'h00;
            bits_q           <= 4'h0;
            group_check_ok_q <= 1'b1;
        end
        else if (gchk_clr)
        begin
            crc_q            <= 16'h0000;
            bits_q           <= 4'h0;
            group_check_ok_q <= 1'b1;
        end
        else
        begin
            if (f_valid && f_ready)
            begin
                sh_q   <= f_data;
                bits_q <= 4'h8;
            end
            else if (bits_q != 4'h0)
            begin
                crc_q  <= crc_bit(crc_q, sh_q[7]);
                sh_q   <= {sh_q[6:0], 1'b0};
                bits_q <= bits_q - 4'h1;
            end
            group_check_ok_q <= (crc_q == 16'h0000);
        end
    end

endmodule // mrc_ctrl_regs

// File: hw/mrc_fifo.v
// parameterised synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module mrc_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk,
    input  wire             arst_n,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_q;
    reg [AW-1:0]    rd_q;
    reg [AW:0]      cnt_q;
    wire            push;
    wire            pop;

    // honest full and empty from the occupancy count
    assign in_ready  = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data  = mem[rd_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // storage write
    always @(posedge clk)
    begin
        if (push)
            mem[wr_q] <= in_data;
    end

    // pointers and count
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ?
                        {AW{1'b0}} : wr_q + 1'b1;
            if (pop)
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ?
                        {AW{1'b0}} : rd_q + 1'b1;
            if (push & ~pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop & ~push)
                cnt_q <= cnt_q - 1'b1;
        end
    end

endmodule // mrc_fifo

// File: hw/mrc_map.vh
// register offsets, field positions and frame figures of the control group
`ifndef MRC_MAP_VH
`define MRC_MAP_VH

// register offsets (4-bit address)
`define MRC_ADDR_W          4
`define MRC_OFS_GUARD       4'h3
`define MRC_OFS_CONTROL_ONE        4'h4
`define MRC_OFS_CONTROL_TWO        4'h5
`define MRC_OFS_GCHK        4'h6

// reset values
`define MRC_RST_GUARD       8'h17
`define MRC_RST_CONTROL_ONE        8'h00
`define MRC_RST_CONTROL_TWO        8'h00

// control_one fields
`define MRC_C1_FRAME_A      0
`define MRC_C1_NO_RTB       1
`define MRC_C1_COL_HALT     2
`define MRC_C1_CORR_STOP    3
`define MRC_C1_SYNC_RST     4
`define MRC_C1_OUT_ALL      5
`define MRC_C1_SER_MOVE     6
`define MRC_C1_GCHK_CLR     7

// control_two fields
`define MRC_C2_DMA_EN       0
`define MRC_C2_DMA_ACK_RD   1
`define MRC_C2_UNCORR_OUT   2
`define MRC_C2_RDY_T2       3
`define MRC_C2_REQ_POL      4
`define MRC_C2_ACK_POL      5
`define MRC_C2_BLOCK_LOCK_RESET      6
`define MRC_C2_SUBST        7

// frame structure figures
`define MRC_MARKS_PER_FRAME 4
`define MRC_PARITY_BLOCKS   82
`define MRC_MAX_DATA_IN_PAR 12

// group check generator x^16 + x^12 + x^5 + 1
`define MRC_CRC_POLY        16'h1021
`define MRC_CRC_W           16

`endif

// File: verification/mrc_ctrl_regs_sva.sv
// concurrent checks on the ports of the control register group
`timescale 1ns/100ps
module mrc_ctrl_regs_sva #(
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW    = 4
) (
    input wire       clk,
    input wire       arst_n,
    input wire       interface_select,
    input wire       par_wr,
    input wire [3:0] par_addr,
    input wire [7:0] par_wdata,
    input wire       ser_wr,
    input wire [3:0] ser_addr,
    input wire [7:0] ser_wdata,
    input wire       word_valid,
    input wire       word_corrected,
    input wire       ser_data_active,
    input wire       transfer_request_raw,
    input wire       frame_lock_q,
    input wire       block_lock_q,
    input wire       frame_method_a_q,
    input wire       realtime_block_option_q,
    input wire       column_fix_halt_q,
    input wire       correction_stop_q,
    input wire       word_out_q,
    input wire       int_out_q,
    input wire       ser_oe_q,
    input wire       transfer_request_q,
    input wire       dma_enable_q,
    input wire       ready_timing2_q,
    input wire       substation_flag_q,
    input wire       group_check_ok_q
);
    // ----
    // shadow of the two control registers
    // ----
    wire       sel = interface_select;
    wire       wr  = sel ? ser_wr : par_wr;
    wire [3:0] ad  = sel ? ser_addr : par_addr;
    wire [7:0] wd  = sel ? ser_wdata : par_wdata;
    reg  [7:0] c1_q;
    reg  [7:0] c2_q;

    // follow writes on the selected bus only
    always @(posedge clk or negedge arst_n)
        if (!arst_n)
        begin
            c1_q <= 8'h00;
            c2_q <= 8'h00;
        end
        else
        begin
            if (wr && ad == 4'h4)
                c1_q <= wd;
            if (wr && ad == 4'h5)
                c2_q <= wd;
        end

    // ----
    // assertions
    // ----
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    control_one_copy_a: assert property (
        {correction_stop_q, column_fix_halt_q, realtime_block_option_q,
         frame_method_a_q} == $past(c1_q[3:0]))
        else $error("control one copies wrong");
    control_two_copy_a: assert property (
        !sel && $past(!sel) |-> dma_enable_q == $past(c2_q[0])
        && ready_timing2_q == $past(c2_q[3])
        && substation_flag_q == $past(c2_q[7]))
        else $error("control two copies wrong");
    par_release_a: assert property (!sel && $past(!sel) |-> !ser_oe_q)
        else $error("serial pin driven in parallel mode");
    idle_release_a: assert property (
        sel && $past(sel) && !$past(c1_q[6]) && !$past(ser_data_active)
        |-> !ser_oe_q)
        else $error("serial pin driven while idle");
    reset_quiet_a: assert property (
        (c1_q[4] || c2_q[6]) [*3] |-> !int_out_q && !ser_oe_q)
        else $error("output active during sync reset");
    sync_clear_a: assert property (
        c1_q[4] [*3] |-> !frame_lock_q && !block_lock_q)
        else $error("lock held during sync reset");
    block_clear_a: assert property (
        c2_q[6] && $past(c2_q[6]) && $past(c2_q[6], 2) |-> !block_lock_q)
        else $error("block lock held during block reset");
    check_clear_a: assert property (c1_q[7] [*3] |-> group_check_ok_q)
        else $error("division register not cleared");
    req_idle_a: assert property (
        !sel && $past(!sel) && !$past(transfer_request_raw)
        |-> transfer_request_q == !$past(c2_q[4]))
        else $error("request idle level wrong");
    word_gate_a: assert property (
        word_valid && !word_corrected && !c1_q[5] |=> !word_out_q)
        else $error("uncorrected word passed gate");
endmodule // mrc_ctrl_regs_sva

bind mrc_ctrl_regs mrc_ctrl_regs_sva #(
    .FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW)) u_sva (.*);

// File: verification/mrc_host_model.sv
// host model that issues register writes on the selected bus
`timescale 1ns/100ps
module mrc_host_model (
    input  wire       clk,
    input  wire       interface_select,
    output reg        par_wr,
    output reg  [3:0] par_addr,
    output reg  [7:0] par_wdata,
    output reg        ser_wr,
    output reg  [3:0] ser_addr,
    output reg  [7:0] ser_wdata
);
    // idle bus at time zero
    initial
    begin
        par_wr = 1'b0;
        ser_wr = 1'b0;
        {par_addr, par_wdata, ser_addr, ser_wdata} = 24'h000000;
    end

    // one write on the selected bus
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge clk);
            if (interface_select)
                ser_wr <= 1'b1;
            else
                par_wr <= 1'b1;
            {par_addr, par_wdata, ser_addr, ser_wdata} <= {a, d, a, d};
            @(posedge clk);
            par_wr <= 1'b0;
            ser_wr <= 1'b0;
            {par_addr, par_wdata, ser_addr, ser_wdata} <= ~{a, d, a, d};
        end
    endtask
endmodule // mrc_host_model

// File: verification/test_mrc_ctrl_regs.sv
// self-checking bench for the control register group
`timescale 1ns/100ps
module test_mrc_ctrl_regs;
    logic        clk = 1'b0, arst_n = 1'b0, interface_select = 1'b0;
    logic        ser_gchk_valid = 1'b0, frame_mark = 1'b0, frame_match = 1'b0;
    logic        block_mark = 1'b0, block_match = 1'b0, word_valid = 1'b0;
    logic        word_corrected = 1'b0, word_l2_ok = 1'b0;
    logic        word_column_fixed = 1'b0, int_raw = 1'b1;
    logic        ser_data_active = 1'b0, transfer_request_raw = 1'b0;
    logic [7:0]  ser_gchk_data = 8'h00;
    logic [15:0] crc;
    wire         par_wr, ser_wr, gchk_ready, frame_lock_q, block_lock_q;
    wire         frame_method_a_q, realtime_block_option_q, column_fix_halt_q;
    wire         correction_stop_q, word_out_q, int_out_q, ser_oe_q;
    wire         transfer_request_q, dma_enable_q, ready_timing2_q;
    wire         substation_flag_q, group_check_ok_q;
    wire [3:0]   par_addr, ser_addr;
    wire [7:0]   par_wdata, ser_wdata;
    int          n_errors = 0, compares = 0;

    mrc_host_model host (.*);

    mrc_ctrl_regs dut (.*, .frame_error_free(1'b0), .ser_data_raw(1'b0),
        .transfer_acknowledge(1'b0), .ser_out_q(), .read_strobe_q());

    // 25 MHz clock
    always #20 clk = ~clk;

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input string nm, input logic [7:0] seen, exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic w(input logic [3:0] a, input logic [7:0] d);
        host.wr(a, d);
        #1;
    endtask

    // n frame and block marks, all agreeing or all disagreeing
    task automatic marks(input int n, input logic m);
        repeat (n)
        begin
            @(posedge clk);
            {frame_mark, block_mark, frame_match, block_match} <= {2'b11, m, m};
            @(posedge clk);
            {frame_mark, block_mark} <= 2'b00;
            repeat (2) @(posedge clk);
        end
    endtask

    task automatic lk(input logic f, b);
        tick(3);
        chk("frame_lock", frame_lock_q, f);
        chk("block_lock", block_lock_q, b);
    endtask

    // one data word, then watch four cycles for it at the output
    task automatic word(input logic c, exp);
        logic seen;
        seen = 1'b0;
        @(posedge clk);
        {word_valid, word_corrected, word_l2_ok, word_column_fixed} <=
            {1'b1, c, c, c};
        repeat (4)
        begin
            @(posedge clk);
            word_valid <= 1'b0;
            #1 seen = seen | (word_out_q === 1'b1);
        end
        chk("word_out", seen, exp);
    endtask

    // group check byte through the parallel register at offset six
    task automatic gb(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
            crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ b[i]) ? 16'h1021 : 16'h0000);
        w(4'h6, b);
    endtask

    task automatic wrap_up;
        $display("n_errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // cut a hang short
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        wrap_up;
    end

    // ----
    // main sequence
    // ----
    initial
    begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        tick(1);
        chk("req_idle", transfer_request_q, 1'b1);
        chk("gchk_ok", group_check_ok_q, 1'b1);
        // default counts: lock on 2 matches, drop on 8 misses
        marks(1, 1);
        lk(0, 0);
        marks(1, 1);
        lk(1, 1);
        marks(7, 0);
        lk(1, 1);
        marks(1, 0);
        lk(0, 0);
        marks(1, 1);
        marks(1, 0);
        marks(1, 1);
        lk(0, 0);
        marks(1, 0);
        w(4'h3, 8'h21);
        marks(2, 1);
        lk(0, 1);
        marks(1, 1);
        lk(1, 1);
        marks(2, 0);
        lk(0, 1);
        marks(3, 1);
        w(4'h5, 8'h40);
        lk(1, 0);
        w(4'h5, 8'h00);
        w(4'h4, 8'h10);
        marks(3, 1);
        lk(0, 0);
        w(4'h4, 8'h00);
        marks(2, 1);
        lk(0, 1);
        marks(1, 1);
        lk(1, 1);
        // output gating while locked
        word(1, 1);
        word(0, 0);
        w(4'h4, 8'h24);
        word(0, 1);
        w(4'h4, 8'h28);
        word(1, 0);
        w(4'h4, 8'h02);
        marks(1, 1);
        lk(1, 1);
        marks(1, 1);
        lk(0, 1);
        for (int i = 0; i < 4; i++)
        begin
            w(4'h4, 8'h01 << i);
            tick(1);
            chk("control_one", {correction_stop_q, column_fix_halt_q,
                realtime_block_option_q, frame_method_a_q}, 8'h01 << i);
        end
        w(4'h7, 8'hFF);
        w(4'h0, 8'hFF);
        tick(1);
        chk("unmapped", {correction_stop_q, frame_method_a_q}, 8'h02);
        w(4'h5, 8'h89);
        tick(1);
        chk("control_two", {substation_flag_q, ready_timing2_q, dma_enable_q},
            8'h07);
        w(4'h4, 8'h00);
        w(4'h5, 8'h11);
        tick(1);
        chk("req_idle_hi", transfer_request_q, 1'b0);
        transfer_request_raw <= 1'b1;
        tick(2);
        chk("req_act_hi", transfer_request_q, 1'b1);
        w(4'h5, 8'h01);
        tick(1);
        chk("req_act_lo", transfer_request_q, 1'b0);
        // fill the fifo while the check is held cleared
        w(4'h4, 8'h80);
        crc = 16'h0000;
        for (int i = 0; i < 14; i++)
            gb(8'h3C ^ 8'(i));
        w(4'h6, crc[15:8]);
        w(4'h6, crc[7:0]);
        chk("gchk_ready", gchk_ready, 1'b0);
        w(4'h6, 8'h5A);
        w(4'h4, 8'h00);
        tick(200);
        chk("gchk_ok", group_check_ok_q, 1'b1);
        // serial side: byte strobe and register writes
        interface_select <= 1'b1;
        ser_gchk_valid <= 1'b1;
        ser_gchk_data <= 8'h01;
        tick(1);
        ser_gchk_valid <= 1'b0;
        tick(14);
        chk("gchk_bad", group_check_ok_q, 1'b0);
        w(4'h4, 8'h80);
        tick(3);
        chk("gchk_clr", group_check_ok_q, 1'b1);
        w(4'h4, 8'h0F);
        tick(1);
        chk("ser_control_one", {correction_stop_q, frame_method_a_q}, 8'h03);
        w(4'h4, 8'h00);
        ser_data_active <= 1'b1;
        tick(2);
        chk("ser_oe_act", ser_oe_q, 1'b1);
        w(4'h4, 8'h10);
        tick(2);
        chk("ser_oe_rst", ser_oe_q, 1'b0);
        w(4'h4, 8'h00);
        ser_data_active <= 1'b0;
        tick(2);
        chk("ser_oe_idle", ser_oe_q, 1'b0);
        wrap_up;
    end
endmodule // test_mrc_ctrl_regs
